/* bridge_output_control.sv */
module bridge_output_control (
  input  wire logic                                mclk_i,
  input  wire logic                                rst_i,
  input  wire logic [bridge_ctrl_pkg::ADDR_W-1:0]  addr_i,
  input  wire logic [bridge_ctrl_pkg::DATA_W-1:0]  wdata_i,
  input  wire logic                                wr_i,
  input  wire logic                                rd_i,
  output logic      [bridge_ctrl_pkg::DATA_W-1:0]  rdata_o,
  input  wire logic                                output_buffer_supply_i,
  input  wire logic                                first_control_pin_i,
  input  wire logic                                second_control_pin_i,
  input  wire logic                                active_low_enable_pin_n_i,
  input  wire logic                                output_disable_pin_i,
  input  wire logic                                standby_state_i,
  input  wire logic                                overtemperature_fault_i,
  input  wire logic                                die_temperature_warning_i,
  input  wire logic                                overvoltage_fault_i,
  input  wire logic                                undervoltage_fault_i,
  input  wire logic                                first_output_ground_short_i,
  input  wire logic                                second_output_ground_short_i,
  input  wire logic                                first_output_supply_short_i,
  input  wire logic                                second_output_supply_short_i,
  input  wire logic                                load_over_limit_i,
  input  wire logic                                overshoot_seen_i,
  input  wire logic                                first_output_high_i,
  output logic                                     high_side1_o,
  output logic                                     low_side1_o,
  output logic                                     high_side2_o,
  output logic                                     low_side2_o,
  output logic                                     open_load_pullup_o,
  output logic      [2:0]                          slew_rate_o,
  output logic                                     slew_bypass_o,
  output logic      [1:0]                          current_limit_sel_o
);
  import bridge_ctrl_pkg::*;

  localparam int SYNC_W = 17;
  // Both stages start at the idle pin levels: supply low, enable high, standby high.
  // A mismatch between them would fake a standby edge right after reset.
  localparam logic [SYNC_W-1:0] SYNC_RST = 17'h02800;

  logic [SYNC_W-1:0] raw;
  logic [SYNC_W-1:0] s1_q;
  logic [SYNC_W-1:0] s2_q;
  logic              output_buffer_supply, in1, in2, active_low_enable_pin_n, dis, standby_state, ot, die_temperature_warning, ov, uv;
  logic              first_output_ground_short, second_output_ground_short, first_output_supply_short, second_output_supply_short, over, osh, o1hi;
  logic [15:0]       ctrl_q;
  logic [FLAG_W-1:0] flags_q;
  logic [FLAG_W-1:0] flag_set;
  logic [FLAG_W-1:0] flag_clr;
  logic              ols_q, ola_q, win_q, seen_q, standby_state_q, ol_req_q;
  logic              pwm_eff_q, slew_bypass_q;
  logic [DATA_W-1:0] rdata_q;
  logic [3:0]        g_q;
  logic [3:0]        g_prev_q;
  logic [3:0]        g_d;
  logic              pull_q, pull_d;
  lim_state_e        lim_st;
  ol_state_e         ol_st;
  logic [CNT_W-1:0]  lim_cnt_q;
  logic [CNT_W-1:0]  ol_cnt_q;
  logic              full, ser, cmd_a, cmd_b, sc1, sc2, any_sc;
  logic              off_all, lim_start, lim_reset, ol_start, recirc, wr_ctrl;

  // Every pin and comparator comes from outside this clock, so two flops first.
  assign raw = {output_buffer_supply_i, first_control_pin_i, second_control_pin_i,
                active_low_enable_pin_n_i, output_disable_pin_i, standby_state_i,
                overtemperature_fault_i, die_temperature_warning_i, overvoltage_fault_i,
                undervoltage_fault_i, first_output_ground_short_i, second_output_ground_short_i,
                first_output_supply_short_i, second_output_supply_short_i, load_over_limit_i,
                overshoot_seen_i, first_output_high_i};
  assign {output_buffer_supply, in1, in2, active_low_enable_pin_n, dis, standby_state, ot, die_temperature_warning, ov, uv,
          first_output_ground_short, second_output_ground_short, first_output_supply_short, second_output_supply_short, over, osh, o1hi} = s2_q;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_q <= SYNC_RST;
      s2_q <= SYNC_RST;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end

  // Command sources: pins in parallel mode, virtual bits in serial mode.
  assign full   = ctrl_q[CTRL_FULL];
  assign ser    = ctrl_q[CTRL_SERIAL];
  assign cmd_a  = ser ? ctrl_q[CTRL_FIRST_VIRTUAL_INPUT_BIT] : in1;
  assign cmd_b  = ser ? ctrl_q[CTRL_SECOND_VIRTUAL_INPUT_BIT] : in2;
  assign sc1    = flags_q[ST_FIRST_OUTPUT_GROUND_SHORT] | flags_q[ST_FIRST_OUTPUT_SUPPLY_SHORT];
  assign sc2    = flags_q[ST_SECOND_OUTPUT_GROUND_SHORT] | flags_q[ST_SECOND_OUTPUT_SUPPLY_SHORT];
  assign any_sc = sc1 | sc2;
  assign wr_ctrl = wr_i && addr_i == ADDR_CTRL;

  // Sources that switch the whole bridge off, highest rank first.
  assign off_all = !active_low_enable_pin_n || dis || uv || ctrl_q[CTRL_DIS] || flags_q[ST_OT]
                   || (full && any_sc);
  assign recirc  = full && (ov || lim_st == LIM_DECAY || lim_st == LIM_HOLD);
  assign lim_reset = !full || standby_state || off_all || !cmd_b;
  assign lim_start = full && lim_st == LIM_IDLE && pwm_eff_q && over;
  assign ol_start  = full && ((standby_state_q && !standby_state) || (standby_state && ol_req_q))
                     && ctrl_q[CTRL_OL_EN];

  // Control register write; the open-load request pulses on a low to high write.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q   <= CTRL_RESET;
      ol_req_q <= 1'b0;
    end else begin
      ol_req_q <= wr_ctrl && wdata_i[CTRL_OL_EN] && !ctrl_q[CTRL_OL_EN];
      if (wr_ctrl) begin
        ctrl_q <= {5'h00, wdata_i[10:0]};
      end
    end
  end

  // Sticky fault flags; a new event in the clearing cycle wins over the clear.
  assign flag_set = {uv, ov, second_output_supply_short, first_output_supply_short, second_output_ground_short, first_output_ground_short, lim_start, ot};
  assign flag_clr = (wr_i && addr_i == ADDR_CLEAR) ? wdata_i[FLAG_W-1:0] : '0;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      flags_q <= '0;
    end else begin
      flags_q <= (flags_q & ~flag_clr) | flag_set;
    end
  end

  // Slew and limit selections go straight to the analog drivers.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      slew_bypass_q <= 1'b0;
    end else begin
      slew_bypass_q <= ctrl_q[CTRL_SR_HI:CTRL_SR_LO] == 3'h0;
    end
  end
  assign slew_rate_o         = ctrl_q[CTRL_SR_HI:CTRL_SR_LO];
  assign slew_bypass_o       = slew_bypass_q;
  assign current_limit_sel_o = ctrl_q[CTRL_IL_HI:CTRL_IL_LO];

  // Effective PWM: off takes effect at once, on waits for current to fall.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pwm_eff_q <= 1'b0;
    end else if (!cmd_b) begin
      pwm_eff_q <= 1'b0;
    end else if (!over) begin
      pwm_eff_q <= 1'b1;
    end
  end

  // Current-limit sequencer: blank, measure decay, hold for twice the decay.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      lim_st    <= LIM_IDLE;
      lim_cnt_q <= '0;
    end else if (lim_reset) begin
      lim_st    <= LIM_IDLE;
      lim_cnt_q <= '0;
    end else begin
      unique case (lim_st)
        LIM_IDLE: begin
          if (lim_start) begin
            lim_st    <= LIM_BLANK;
            // Length is taken once here so a warning change cannot stretch it.
            lim_cnt_q <= die_temperature_warning ? CNT_W'(BLANK_HOT_CYC - 1) : CNT_W'(BLANK_CYC - 1);
          end
        end
        LIM_BLANK: begin
          if (lim_cnt_q == '0) begin
            lim_st <= LIM_DECAY;
          end else begin
            lim_cnt_q <= lim_cnt_q - 1'b1;
          end
        end
        LIM_DECAY: begin
          if (!over) begin
            lim_st    <= LIM_HOLD;
            lim_cnt_q <= {lim_cnt_q[CNT_W-2:0], 1'b0};
          end else if (lim_cnt_q != CNT_W'(DECAY_MAX)) begin
            lim_cnt_q <= lim_cnt_q + 1'b1;
          end
        end
        LIM_HOLD: begin
          if (lim_cnt_q <= CNT_W'(1)) begin
            lim_st <= LIM_IDLE;
          end else begin
            lim_cnt_q <= lim_cnt_q - 1'b1;
          end
        end
      endcase
    end
  end

  // Standby open-load check; any disabling fault aborts it.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ol_st    <= OL_IDLE;
      ol_cnt_q <= '0;
      ols_q    <= 1'b0;
      standby_state_q   <= 1'b1;
    end else begin
      standby_state_q <= standby_state;
      if (wr_i && addr_i == ADDR_CLEAR && wdata_i[ST_OLS]) begin
        ols_q <= 1'b0;
      end
      if (off_all || !full) begin
        ol_st <= OL_IDLE;
      end else begin
        unique case (ol_st)
          OL_IDLE: begin
            if (ol_start) begin
              ol_st    <= OL_DISCHARGE;
              ol_cnt_q <= CNT_W'(OL_DISCHARGE_CYC - 1);
            end
          end
          OL_DISCHARGE: begin
            if (ol_cnt_q == '0) begin
              ol_st    <= OL_PULLUP;
              ol_cnt_q <= CNT_W'(OL_FILTER_CYC - 1);
            end else begin
              ol_cnt_q <= ol_cnt_q - 1'b1;
            end
          end
          OL_PULLUP: begin
            if (ol_cnt_q == '0) begin
              ol_st <= OL_IDLE;
              if (o1hi) begin
                ols_q <= 1'b1;
              end
            end else begin
              ol_cnt_q <= ol_cnt_q - 1'b1;
            end
          end
        endcase
      end
    end
  end

  // Gate drive selection; gate order is {hs1, ls1, hs2, ls2}.
  always_comb begin
    g_d    = 4'h0;
    pull_d = 1'b0;
    if (off_all) begin
      g_d = 4'h0;
    end else if (ol_st == OL_DISCHARGE) begin
      g_d = 4'h5;
    end else if (ol_st == OL_PULLUP) begin
      g_d    = 4'h1;
      pull_d = 1'b1;
    end else if (standby_state) begin
      g_d = 4'h0;
    end else if (full) begin
      if (recirc) begin
        g_d = 4'ha;
      end else if (!pwm_eff_q) begin
        g_d = 4'h5;
      end else begin
        g_d = cmd_a ? 4'h9 : 4'h6;
      end
    end else begin
      // Each half-bridge follows its own input and its own short flag.
      g_d[3:2] = sc1 ? 2'b00 : (cmd_a ? 2'b10 : 2'b01);
      g_d[1:0] = sc2 ? 2'b00 : (cmd_b ? 2'b10 : 2'b01);
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      g_q      <= 4'h0;
      g_prev_q <= 4'h0;
      pull_q   <= 1'b0;
    end else begin
      g_q      <= g_d;
      g_prev_q <= g_q;
      pull_q   <= pull_d;
    end
  end
  assign {high_side1_o, low_side1_o, high_side2_o, low_side2_o} = g_q;
  assign open_load_pullup_o = pull_q;

  // Active open load: a window runs from a low side going off to one coming on.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      win_q  <= 1'b0;
      seen_q <= 1'b0;
      ola_q  <= 1'b0;
    end else if (!full || standby_state) begin
      win_q  <= 1'b0;
      seen_q <= 1'b0;
      ola_q  <= 1'b0;
    end else if (win_q && ((g_q[2] && !g_prev_q[2]) || (g_q[0] && !g_prev_q[0]))) begin
      win_q <= 1'b0;
      ola_q <= !(seen_q || osh);
    end else if ((!g_q[2] && g_prev_q[2]) || (!g_q[0] && g_prev_q[0])) begin
      win_q  <= 1'b1;
      seen_q <= osh;
    end else if (win_q && osh) begin
      seen_q <= 1'b1;
    end
  end

  // Read port; a dead output supply forces an all-zero word.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= '0;
    end else if (!rd_i || !output_buffer_supply) begin
      rdata_q <= '0;
    end else begin
      unique case (addr_i)
        ADDR_CTRL:   rdata_q <= ctrl_q;
        ADDR_STATUS: rdata_q <= {4'h0, ol_st != OL_IDLE, ola_q, ols_q, die_temperature_warning, flags_q};
        default:     rdata_q <= '0;
      endcase
    end
  end
  assign rdata_o = rdata_q;

  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  rdata_zero_a: assert property (rd_i && !output_buffer_supply |=> rdata_o == '0)
    else $error("read data not zero with output supply down");
  half_follow_a: assert property (!full && !off_all && !standby_state && !sc1 && !ser && ol_st == OL_IDLE
                                  |=> high_side1_o == $past(in1))
    else $error("half-bridge output one does not follow its pin");
  full_dir_a: assert property (full && !off_all && !standby_state && !recirc && ol_st == OL_IDLE && pwm_eff_q
                               |=> high_side1_o == $past(cmd_a) && low_side2_o == $past(cmd_a))
    else $error("full-bridge direction not taken from command");
  half_quiet_a: assert property (!full |=> lim_st == LIM_IDLE && ol_st == OL_IDLE)
    else $error("limit or open-load active in half-bridge");
  short_off_a: assert property (full && any_sc |=> g_q == 4'h0)
    else $error("bridge not off after short");
  active_low_enable_pin_dom_a: assert property (!active_low_enable_pin_n |=> g_q == 4'h0 && !open_load_pullup_o)
    else $error("enable pin does not dominate");
  blank_len_a: assert property (lim_start && !lim_reset
                                |=> lim_cnt_q == ($past(die_temperature_warning) ? BLANK_HOT_CYC - 1 : BLANK_CYC - 1))
    else $error("blanking length wrong");
  blank_end_a: assert property (lim_st == LIM_BLANK && lim_cnt_q == '0 && !lim_reset |=> lim_st == LIM_DECAY)
    else $error("no recirculation after blanking");
  hold_twice_a: assert property (lim_st == LIM_DECAY && !over && !lim_reset
                                 |=> lim_cnt_q == 2 * $past(lim_cnt_q))
    else $error("hold time is not twice the decay");
  off_reset_a: assert property (full && !cmd_b |=> lim_st == LIM_IDLE && !pwm_eff_q)
    else $error("off command did not reset the limit");
  on_block_a: assert property (!pwm_eff_q && over |=> !pwm_eff_q)
    else $error("output turned on above the limit");
  ol_pull_a: assert property (ol_st == OL_PULLUP && !off_all |=> open_load_pullup_o && low_side2_o && !low_side1_o)
    else $error("pull-up stage gates wrong");
endmodule // bridge_output_control

/* bridge_ctrl_pkg.sv */
package bridge_ctrl_pkg;
  // Core clock rate and the timing figures of the current-limit loop and the standby open-load check.
  localparam int CLK_MHZ         = 10;
  localparam int BLANK_US        = 32;
  localparam int BLANK_HOT_US    = 256;
  localparam int BLANK_CYC       = BLANK_US * CLK_MHZ;
  localparam int BLANK_HOT_CYC   = BLANK_HOT_US * CLK_MHZ;
  localparam int OL_DISCHARGE_US = 16;
  localparam int OL_FILTER_US    = 32;
  localparam int OL_DISCHARGE_CYC = OL_DISCHARGE_US * CLK_MHZ;
  localparam int OL_FILTER_CYC   = OL_FILTER_US * CLK_MHZ;
  localparam int CNT_W           = 13;
  localparam int DECAY_MAX       = 4095;

  // Register bus layout.
  localparam int ADDR_W = 2;
  localparam int DATA_W = 16;
  localparam logic [1:0] ADDR_CTRL   = 2'h0;
  localparam logic [1:0] ADDR_STATUS = 2'h1;
  localparam logic [1:0] ADDR_CLEAR  = 2'h2;

  // Control register fields.
  localparam int CTRL_FULL   = 0;
  localparam int CTRL_SERIAL = 1;
  localparam int CTRL_FIRST_VIRTUAL_INPUT_BIT   = 2;
  localparam int CTRL_SECOND_VIRTUAL_INPUT_BIT   = 3;
  localparam int CTRL_DIS    = 4;
  localparam int CTRL_OL_EN  = 5;
  localparam int CTRL_SR_LO  = 6;
  localparam int CTRL_SR_HI  = 8;
  localparam int CTRL_IL_LO  = 9;
  localparam int CTRL_IL_HI  = 10;
  localparam logic [15:0] CTRL_RESET = 16'h0301;

  // Status register fields; bits 7..0 are sticky, write one to clear.
  localparam int ST_OT   = 0;
  localparam int ST_OC   = 1;
  localparam int ST_FIRST_OUTPUT_GROUND_SHORT = 2;
  localparam int ST_SECOND_OUTPUT_GROUND_SHORT = 3;
  localparam int ST_FIRST_OUTPUT_SUPPLY_SHORT = 4;
  localparam int ST_SECOND_OUTPUT_SUPPLY_SHORT = 5;
  localparam int ST_OV   = 6;
  localparam int ST_UV   = 7;
  localparam int ST_OTW  = 8;
  localparam int ST_OLS  = 9;
  localparam int ST_OLA  = 10;
  localparam int ST_OLB  = 11;
  localparam int FLAG_W  = 8;

  typedef enum logic [1:0] {LIM_IDLE, LIM_BLANK, LIM_DECAY, LIM_HOLD} lim_state_e;
  typedef enum logic [1:0] {OL_IDLE, OL_DISCHARGE, OL_PULLUP} ol_state_e;
endpackage

/* load_model.sv */
// Behavioural power stage and load seen from the gate outputs.
module load_model #(
  parameter int DECAY = 40
) (
  input  wire logic mclk_i,
  input  wire logic high_side1_i,
  input  wire logic low_side1_i,
  input  wire logic high_side2_i,
  input  wire logic low_side2_i,
  input  wire logic pullup_i,
  input  wire logic surge_i,
  input  wire logic open_i,
  output logic      over_o,
  output logic      overshoot_o,
  output logic      first_bridge_output_high_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int dcnt = 0;
  logic over_q = 1'b0;
  // Current rises while the bridge drives the load, decays over DECAY cycles in high-side recirculation and drops at once otherwise.
  always @(posedge mclk_i) begin
    if (high_side1_i && high_side2_i) begin
      if (dcnt == DECAY - 1) over_q <= 1'b0;
      else dcnt <= dcnt + 1;
    end else begin
      dcnt <= 0;
      over_q <= surge_i && ((high_side1_i && low_side2_i) || (high_side2_i && low_side1_i));
    end
  end
  // A present inductive load flies back while a high side conducts; an open one never does.
  assign overshoot_o = !open_i && (high_side1_i || high_side2_i);
  // With a load fitted, output two's low side holds output one down against the pull-up.
  assign first_bridge_output_high_o = pullup_i && open_i;
  assign over_o = over_q;
endmodule // load_model

/* bridge_output_control_tb.sv */
module bridge_output_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import bridge_ctrl_pkg::*;
  logic mclk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, sup = 1, in1 = 0, in2 = 0, en_n = 1, dis = 0, standby_state = 1;
  logic in2_set = 0;
  logic ot = 0, die_temperature_warning = 0, ov = 0, uv = 0, g1 = 0, g2 = 0, p1 = 0, p2 = 0, surge = 0, open = 0, pwm_run = 0;
  logic [1:0] addr_i = '0;
  logic [15:0] wdata_i = '0, rdata_o, rv;
  logic hs1, ls1, hs2, ls2, pu, over, osh, o1h, byp;
  logic [2:0] slew;
  logic [1:0] lim;
  wire [3:0] g = {hs1, ls1, hs2, ls2};
  int error_cnt = 0, n_checks = 0, n;
  // The core clock; the link-rate PWM below runs at eight of its periods.
  always #50 mclk_i = ~mclk_i;
  // The second control pin follows in2_set, or runs a square wave of 800 ns while requested.
  int pcnt = 0;
  always @(posedge mclk_i) begin
    if (pwm_run) begin
      pcnt <= (pcnt + 1) % 4;
      if (pcnt == 3) in2 <= ~in2;
    end else begin
      in2 <= in2_set;
    end
  end
  bridge_output_control dut (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .output_buffer_supply_i(sup), .first_control_pin_i(in1),
    .second_control_pin_i(in2), .active_low_enable_pin_n_i(en_n), .output_disable_pin_i(dis),
    .standby_state_i(standby_state), .overtemperature_fault_i(ot), .die_temperature_warning_i(die_temperature_warning),
    .overvoltage_fault_i(ov), .undervoltage_fault_i(uv), .first_output_ground_short_i(g1),
    .second_output_ground_short_i(g2), .first_output_supply_short_i(p1), .second_output_supply_short_i(p2),
    .load_over_limit_i(over), .overshoot_seen_i(osh), .first_output_high_i(o1h), .high_side1_o(hs1),
    .low_side1_o(ls1), .high_side2_o(hs2), .low_side2_o(ls2), .open_load_pullup_o(pu), .slew_rate_o(slew),
    .slew_bypass_o(byp), .current_limit_sel_o(lim));
  load_model #(.DECAY(40)) load (.mclk_i(mclk_i), .high_side1_i(hs1), .low_side1_i(ls1), .high_side2_i(hs2),
    .low_side2_i(ls2), .pullup_i(pu), .surge_i(surge), .open_i(open), .over_o(over), .overshoot_o(osh),
    .first_bridge_output_high_o(o1h));
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge mclk_i) begin wr_i <= 1; addr_i <= a; wdata_i <= d; end
    @(posedge mclk_i) wr_i <= 0;
  endtask
  // Read data stand only in the cycle after the strobe edge, so sample just after it.
  task automatic rd(input logic [1:0] a);
    @(posedge mclk_i) begin rd_i <= 1; addr_i <= a; end
    @(posedge mclk_i) rd_i <= 0;
    #1 rv = rdata_o;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk_i);
    #1;
  endtask
  task automatic test_done;
    if (error_cnt == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Bounded wait for a gate pattern to appear (want) or to leave (!want).
  task automatic wait_g(input logic [3:0] p, input logic want);
    for (n = 0; (g == p) != want; n++) begin
      if (n > 3000) begin
        chk("gate wait", 16'h1, 16'h0);
        test_done();
      end
      @(posedge mclk_i);
      #1;
    end
  endtask
  initial begin
    cyc(20);
    rst_i <= 0;
    cyc(4);
    rd(ADDR_CTRL); chk("ctrl reset", CTRL_RESET, rv);
    chk("limit sel", 16'h1, 16'(lim));
    chk("slew", 16'h4, 16'(slew));
    rd(2'h3); chk("unmapped", 16'h0, rv);
    sup <= 0; cyc(3); rd(ADDR_CTRL); chk("no supply", 16'h0, rv);
    sup <= 1; wr(ADDR_CTRL, 16'h0201); cyc(3); chk("bypass", 16'h1, 16'(byp));
    wr(ADDR_CTRL, 16'h0641); cyc(3); chk("slew1", 16'h7, 16'({byp, slew, lim}));
    wr(ADDR_CTRL, CTRL_RESET); standby_state <= 0;
    // Full bridge: direction then PWM, first from pins, then from the virtual bits.
    for (int m = 0; m < 2; m++) for (int i = 0; i < 4; i++) begin
      if (m == 0) begin in1 <= i[1]; in2_set <= i[0]; end
      else wr(ADDR_CTRL, 16'h0303 | 16'({i[0], i[1], 2'b00}));
      cyc(5); chk("full", (i == 3) ? 16'h9 : (i == 1) ? 16'h6 : 16'h5, 16'(g));
    end
    wr(ADDR_CTRL, 16'h0300);
    for (int i = 0; i < 4; i++) begin
      in1 <= i[1]; in2_set <= i[0]; cyc(5);
      chk("half", 16'({i[1], ~i[1], i[0], ~i[0]}), 16'(g));
    end
    // Each of the disable pin, undervoltage, the enable pin and the DIS bit alone must turn every gate off.
    for (int k = 0; k < 4; k++) begin
      dis <= k == 0; uv <= k == 1; en_n <= k != 2;
      if (k == 3) wr(ADDR_CTRL, 16'h0310);
      cyc(5); chk("off", 16'h0, 16'(g));
    end
    uv <= 0; wr(ADDR_CTRL, 16'h0300); cyc(5); chk("on", 16'ha, 16'(g));
    g1 <= 1; cyc(4); g1 <= 0; cyc(4); chk("leg1 short", 16'h2, 16'(g));
    p2 <= 1; cyc(4); p2 <= 0; cyc(4); chk("two shorts", 16'h0, 16'(g));
    wr(ADDR_CLEAR, 16'h00ff); cyc(5); chk("cleared", 16'ha, 16'(g));
    wr(ADDR_CTRL, CTRL_RESET); g2 <= 1; cyc(4); g2 <= 0; cyc(4);
    chk("bridge short", 16'h0, 16'(g));
    wr(ADDR_CLEAR, 16'h00ff); cyc(5); chk("resume", 16'h9, 16'(g));
    // Overvoltage in full bridge puts the load into high-side recirculation.
    ov <= 1; cyc(5); chk("ov recirc", 16'ha, 16'(g));
    ov <= 0; cyc(5); chk("ov release", 16'h9, 16'(g));
    // Over-limit: blanking, then high-side recirculation for the decay plus twice it.
    surge <= 1; cyc(1); wait_g(4'ha, 1);
    chk("blanking", 16'h1, 16'(n >= 318 && n <= 335));
    surge <= 0; wait_g(4'ha, 0);
    chk("recirc len", 16'h1, 16'(n >= 115 && n <= 135));
    chk("release", 16'h9, 16'(g));
    rd(ADDR_STATUS); chk("oc flag", 16'h1, 16'(rv[ST_OC]));
    // With the temperature warning up, blanking stretches eightfold.
    die_temperature_warning <= 1; surge <= 1; cyc(1); wait_g(4'ha, 1);
    chk("hot blanking", 16'h1, 16'(n >= 2558 && n <= 2575));
    die_temperature_warning <= 0; surge <= 0; wait_g(4'ha, 0);
    chk("hot release", 16'h9, 16'(g));
    // Link-rate PWM into an open load: half on time, no overshoot seen.
    open <= 1; pwm_run <= 1; n = 0;
    repeat (80) begin cyc(1); n += hs1; end
    pwm_run <= 0; chk("pwm duty", 16'h1, 16'(n >= 36 && n <= 44));
    rd(ADDR_STATUS); chk("active ol", 16'h1, 16'(rv[ST_OLA]));
    in1 <= 0; in2_set <= 0; standby_state <= 1; cyc(5); chk("standby", 16'h0, 16'(g));
    wr(ADDR_CTRL, 16'h0321); cyc(80); chk("discharge", 16'h5, 16'(g));
    cyc(200); chk("pullup", 16'h3, 16'({g, pu}));
    cyc(300); chk("restored", 16'h0, 16'({g, pu}));
    rd(ADDR_STATUS); chk("standby ol", 16'h1, 16'(rv[ST_OLS]));
    test_done();
  end
endmodule // bridge_output_control_tb
